// File: core/drfba_pkg.sv
package drfba_pkg;

   // Processor address field that selects the DRAM region.
   localparam int         REGION_HI_BIT  = 31;
   localparam int         REGION_LO_BIT  = 29;
   localparam logic [2:0] DRAM_REGION    = 3'h0;

   // Processor address bits routed to the two low DRAM address outputs.
   localparam int         ROW_HI_BIT     = 12;
   localparam int         ROW_LO_BIT     = 11;
   localparam int         COL_HI_BIT     = 3;
   localparam int         COL_LO_BIT     = 2;

   // Refresh divider.
   localparam int         DIV_WIDTH      = 5;
   localparam int         DIV_TOP_BIT    = DIV_WIDTH - 1;
   localparam int         DIV_RATIO      = 28;
   localparam logic [4:0] DIV_LAST       = 5'(DIV_RATIO - 1);
   localparam logic [4:0] DIV_RESET      = 5'h00;
   localparam logic [4:0] DIV_STEP       = 5'h01;

   // Nominal refresh period produced from the refresh clock.
   localparam int         REFRESH_PERIOD_US = 15;

   // Synchroniser depth for every pin that is not on clk_sys.
   localparam int         SYNC_STAGES    = 2;

   // Burst address codes driven in the three burst states.
   localparam logic [1:0] IDX_ONE        = 2'h1;
   localparam logic [1:0] IDX_TWO        = 2'h2;
   localparam logic [1:0] IDX_THREE      = 2'h3;
   localparam logic [1:0] LOW_ADDR_RESET = 2'h0;

   typedef enum logic [1:0]
   {
      passthrough_state,
      burst_one,
      burst_two,
      burst_three
   } drfba_burst_type;

endpackage

// File: core/drfba_sync.sv
`timescale 1ns/10ps
module drfba_sync
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] stage_one;

   // The first stage is read only by the second, to contain metastability.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stage_one <= '0;
         q         <= '0;
      end
      else
      begin
         stage_one <= d;
         q         <= stage_one;
      end
   end

endmodule

// File: core/drfba_ctrl.sv
`timescale 1ns/10ps
module drfba_ctrl
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,

   // Refresh timing pins
   input  wire logic        refresh_clock,
   input  wire logic        ext_timer_in,
   input  wire logic        use_ext_timer,

   // Processor burst bus, sampled on clk_sys
   input  wire logic        address_strobe_n,
   input  wire logic        last_transfer_flag_n,
   input  wire logic [31:0] proc_addr,

   // Row strobe from the row strobe machine, active high
   input  wire logic        row_strobe,

   // Processor ready, active low
   output logic             dram_ready_out_n,

   // Cycle and refresh state
   output logic             processor_cycle_active,
   output logic             refresh_cycle_active,
   output logic             refresh_request,
   output logic             refresh_rearm_block,
   output logic             divider_top_bit,

   // DRAM address side
   output logic             row_col_select,
   output logic             low_addr_out_bit0,
   output logic             low_addr_out_bit1
);

   logic                          rst_n;
   logic [2:0]                    pin_sync;
   logic                          refresh_clock_s;
   logic                          ext_timer_s;
   logic                          use_ext_s;
   logic                          refresh_clock_prev;
   logic                          refresh_clock_rise;
   logic [4:0]                    divider;
   logic [4:0]                    next_divider;
   logic                          next_top_bit;
   logic                          dram_ready;
   logic                          next_dram_ready;
   logic                          address_strobe;
   logic                          last_transfer_flag;
   logic                          region_hit;
   logic                          next_cycle_active;
   logic                          next_refresh_active;
   logic                          next_request;
   logic                          next_rearm_block;
   drfba_pkg::drfba_burst_type    burst_state;
   drfba_pkg::drfba_burst_type    next_burst_state;
   logic [1:0]                    next_low_addr;
   logic                          ready_mid;
   logic                          ready_last;

   // Reset is asserted at once and released through two flip-flops.
   drfba_sync
   #(
      .WIDTH (1)
   )
   u_reset_sync
   (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .d       (1'b1),
      .q       (rst_n)
   );

   // The refresh clock and the external timer are not on clk_sys.
   drfba_sync
   #(
      .WIDTH (3)
   )
   u_pin_sync
   (
      .clk_sys (clk_sys),
      .arst_n  (rst_n),
      .d       ({use_ext_timer, ext_timer_in, refresh_clock}),
      .q       (pin_sync)
   );

   assign refresh_clock_s    = pin_sync[0];
   assign ext_timer_s = pin_sync[1];
   assign use_ext_s   = pin_sync[2];

   // The strobe and last transfer pins are active low; the logic below works on active-high copies.
   assign address_strobe     = !address_strobe_n;
   assign last_transfer_flag = !last_transfer_flag_n;
   assign region_hit         = proc_addr[drfba_pkg::REGION_HI_BIT:drfba_pkg::REGION_LO_BIT]
                               == drfba_pkg::DRAM_REGION;

   // Ready qualifiers shared by the cycle tracker and the burst machine.
   assign ready_mid  = dram_ready && !last_transfer_flag;
   assign ready_last = dram_ready && last_transfer_flag;

   // Rising edges of the synchronised refresh clock form the divider enable.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         refresh_clock_prev <= 1'b0;
      end
      else
      begin
         refresh_clock_prev <= refresh_clock_s;
      end
   end

   assign refresh_clock_rise = refresh_clock_s && !refresh_clock_prev;

   // The divider counts 0 to 27, so its top bit is high for 12 of 28 counts.
   always_comb
   begin
      next_divider = divider;
      if (refresh_clock_rise)
      begin
         if (divider == drfba_pkg::DIV_LAST)
         begin
            next_divider = drfba_pkg::DIV_RESET;
         end
         else
         begin
            next_divider = divider + drfba_pkg::DIV_STEP;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         divider <= drfba_pkg::DIV_RESET;
      end
      else
      begin
         divider <= next_divider;
      end
   end

   // The external square wave is used only after it passed the synchroniser.
   always_comb
   begin
      if (use_ext_s)
      begin
         next_top_bit = ext_timer_s;
      end
      else
      begin
         next_top_bit = divider[drfba_pkg::DIV_TOP_BIT];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         divider_top_bit <= 1'b0;
      end
      else
      begin
         divider_top_bit <= next_top_bit;
      end
   end

   // Column address select trails the row strobe by one clock both ways.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         row_col_select <= 1'b0;
      end
      else
      begin
         row_col_select <= row_strobe;
      end
   end

   // Ready takes no byte lane term, so it fires even when no lane is enabled.
   always_comb
   begin
      next_dram_ready = dram_ready;
      if (!dram_ready)
      begin
         next_dram_ready = row_strobe && row_col_select && !refresh_cycle_active;
      end
      else if (!refresh_cycle_active)
      begin
         next_dram_ready = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dram_ready       <= 1'b0;
         dram_ready_out_n <= 1'b1;
      end
      else
      begin
         dram_ready       <= next_dram_ready;
         dram_ready_out_n <= !next_dram_ready;
      end
   end

   // The tracker stays low in the address state, so refresh may start there.
   always_comb
   begin
      next_cycle_active = processor_cycle_active;
      if (!processor_cycle_active)
      begin
         next_cycle_active = address_strobe && region_hit;
      end
      else if (ready_last)
      begin
         next_cycle_active = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         processor_cycle_active <= 1'b0;
      end
      else
      begin
         processor_cycle_active <= next_cycle_active;
      end
   end

   // Select is still high in the last refresh clock while the strobe is low.
   always_comb
   begin
      next_refresh_active = refresh_cycle_active;
      if (!refresh_cycle_active)
      begin
         next_refresh_active = refresh_request && !processor_cycle_active;
      end
      else if (!row_strobe && row_col_select)
      begin
         next_refresh_active = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         refresh_cycle_active <= 1'b0;
      end
      else
      begin
         refresh_cycle_active <= next_refresh_active;
      end
   end

   // Request and refresh_rearm_block together turn the top bit level into one request.
   always_comb
   begin
      next_request = refresh_request;
      if (!refresh_request)
      begin
         next_request = divider_top_bit && !refresh_rearm_block;
      end
      else if (refresh_cycle_active)
      begin
         next_request = 1'b0;
      end
   end

   always_comb
   begin
      next_rearm_block = refresh_rearm_block;
      if (!refresh_rearm_block)
      begin
         next_rearm_block = refresh_cycle_active;
      end
      else if (!divider_top_bit)
      begin
         next_rearm_block = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         refresh_request     <= 1'b0;
         refresh_rearm_block <= 1'b0;
      end
      else
      begin
         refresh_request     <= next_request;
         refresh_rearm_block <= next_rearm_block;
      end
   end

   // Burst address sequencing follows the ready and last transfer pair.
   always_comb
   begin
      next_burst_state = burst_state;
      case (burst_state)
         drfba_pkg::passthrough_state:
         begin
            if (ready_mid && !proc_addr[drfba_pkg::COL_HI_BIT] && !proc_addr[drfba_pkg::COL_LO_BIT])
            begin
               next_burst_state = drfba_pkg::burst_one;
            end
            else if (ready_mid && proc_addr[drfba_pkg::COL_HI_BIT] && !proc_addr[drfba_pkg::COL_LO_BIT])
            begin
               next_burst_state = drfba_pkg::burst_three;
            end
            else
            begin
               next_burst_state = drfba_pkg::passthrough_state;
            end
         end
         drfba_pkg::burst_one:
         begin
            if (ready_mid)
            begin
               next_burst_state = drfba_pkg::burst_two;
            end
            else if (ready_last)
            begin
               next_burst_state = drfba_pkg::passthrough_state;
            end
         end
         drfba_pkg::burst_two:
         begin
            if (ready_mid)
            begin
               next_burst_state = drfba_pkg::burst_three;
            end
            else if (ready_last)
            begin
               next_burst_state = drfba_pkg::passthrough_state;
            end
         end
         drfba_pkg::burst_three:
         begin
            if (ready_last)
            begin
               next_burst_state = drfba_pkg::passthrough_state;
            end
         end
         default:
         begin
            next_burst_state = drfba_pkg::passthrough_state;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         burst_state <= drfba_pkg::passthrough_state;
      end
      else
      begin
         burst_state <= next_burst_state;
      end
   end

   // The outputs are registered from next state and next select, so they
   // line up with the state; address bits are those seen one clock earlier.
   always_comb
   begin
      case (next_burst_state)
         drfba_pkg::passthrough_state:
         begin
            if (row_strobe)
            begin
               next_low_addr = {proc_addr[drfba_pkg::COL_HI_BIT], proc_addr[drfba_pkg::COL_LO_BIT]};
            end
            else
            begin
               next_low_addr = {proc_addr[drfba_pkg::ROW_HI_BIT], proc_addr[drfba_pkg::ROW_LO_BIT]};
            end
         end
         drfba_pkg::burst_one:
         begin
            next_low_addr = drfba_pkg::IDX_ONE;
         end
         drfba_pkg::burst_two:
         begin
            next_low_addr = drfba_pkg::IDX_TWO;
         end
         drfba_pkg::burst_three:
         begin
            next_low_addr = drfba_pkg::IDX_THREE;
         end
         default:
         begin
            next_low_addr = drfba_pkg::LOW_ADDR_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         low_addr_out_bit1 <= drfba_pkg::LOW_ADDR_RESET[1];
         low_addr_out_bit0 <= drfba_pkg::LOW_ADDR_RESET[0];
      end
      else
      begin
         low_addr_out_bit1 <= next_low_addr[1];
         low_addr_out_bit0 <= next_low_addr[0];
      end
   end

endmodule

// File: tb/drfba_props.sv
`timescale 1ns/10ps
module drfba_props
(
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        arst_n,
   // Processor side
   input wire logic        address_strobe_n,
   input wire logic        last_transfer_flag_n,
   input wire logic [31:0] proc_addr,
   input wire logic        row_strobe,
   // Controller outputs
   input wire logic        dram_ready_out_n,
   input wire logic        processor_cycle_active,
   input wire logic        refresh_cycle_active,
   input wire logic        refresh_request,
   input wire logic        refresh_rearm_block,
   input wire logic        divider_top_bit,
   input wire logic        row_col_select
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   sequence s_ref_start;
      refresh_request && !processor_cycle_active && !refresh_cycle_active;
   endsequence
   sequence s_ref_grant;
      refresh_cycle_active ##1 (!refresh_request && refresh_rearm_block);
   endsequence

   a_ready_cause: assert property
      (!dram_ready_out_n |-> $past(dram_ready_out_n) && $past(row_col_select) && !$past(refresh_cycle_active))
      else $error("ready without cause");
   a_ready_fire: assert property
      (row_strobe && row_col_select && !refresh_cycle_active && dram_ready_out_n |=> !dram_ready_out_n)
      else $error("ready missing");
   a_ready_pulse: assert property (!dram_ready_out_n && !refresh_cycle_active |=> dram_ready_out_n)
      else $error("ready too long");
   a_ready_refresh: assert property (refresh_cycle_active |-> dram_ready_out_n)
      else $error("ready in refresh");
   a_cycle_start: assert property
      (!address_strobe_n && proc_addr[31:29] == drfba_pkg::DRAM_REGION && !processor_cycle_active
       |=> processor_cycle_active)
      else $error("cycle not tracked");
   a_cycle_end: assert property
      (processor_cycle_active && !dram_ready_out_n && !last_transfer_flag_n |=> !processor_cycle_active)
      else $error("cycle not cleared");
   a_refresh_waits: assert property
      ($rose(refresh_cycle_active) |-> !$past(processor_cycle_active) && $past(refresh_request))
      else $error("refresh started badly");
   a_refresh_handoff: assert property (s_ref_start |=> s_ref_grant)
      else $error("refresh grant wrong");
   a_refresh_end: assert property
      (refresh_cycle_active && !row_strobe && row_col_select |=> !refresh_cycle_active)
      else $error("refresh not ended");
   a_refresh_stay: assert property
      (refresh_cycle_active && (row_strobe || !row_col_select) |=> refresh_cycle_active)
      else $error("refresh ended early");
   a_request_set: assert property
      (divider_top_bit && !refresh_rearm_block && !refresh_cycle_active |=> refresh_request)
      else $error("request missing");
   a_rearm_clear: assert property (!divider_top_bit && !refresh_cycle_active |=> !refresh_rearm_block)
      else $error("rearm stuck");
   a_rearm_keep: assert property (refresh_rearm_block && divider_top_bit |=> refresh_rearm_block)
      else $error("rearm dropped");
   a_select_follow: assert property (row_col_select == $past(row_strobe))
      else $error("select lag wrong");
endmodule

bind drfba_ctrl drfba_props u_props
(
   .clk_sys,
   .arst_n,
   .address_strobe_n,
   .last_transfer_flag_n,
   .proc_addr,
   .row_strobe,
   .dram_ready_out_n,
   .processor_cycle_active,
   .refresh_cycle_active,
   .refresh_request,
   .refresh_rearm_block,
   .divider_top_bit,
   .row_col_select
);

// File: tb/drfba_row_model.sv
`timescale 1ns/10ps
module drfba_row_model
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // Bus and controller state
   input  wire logic        address_strobe_n,
   input  wire logic        last_transfer_flag_n,
   input  wire logic [31:0] proc_addr,
   input  wire logic        dram_ready_out_n,
   input  wire logic        refresh_request,
   input  wire logic        refresh_cycle_active,
   input  wire logic        processor_cycle_active,
   input  wire logic        row_col_select,
   // Row strobe back to the controller
   output logic             row_strobe
);
   logic cas_ref;
   logic row_on;
   logic row_off;

   // A new access waits for select to drop, which gives the row precharge.
   assign row_on = (!address_strobe_n && proc_addr[31:29] == drfba_pkg::DRAM_REGION && !row_col_select
                    && !refresh_request) || (processor_cycle_active && !refresh_cycle_active)
                   || (cas_ref && refresh_cycle_active);
   assign row_off = (!last_transfer_flag_n && !dram_ready_out_n) || (!cas_ref && refresh_cycle_active);

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         cas_ref <= 1'h0;
      else
         cas_ref <= (refresh_request && !processor_cycle_active) || (cas_ref && refresh_cycle_active && !row_strobe);
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         row_strobe <= 1'h0;
      else
         row_strobe <= row_strobe ? !row_off : row_on;
   end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("[ERR] %0t got %h exp %h", $time, got, exp); \
      end \
   end
module tb_top;
   logic        clk_sys;
   logic        arst_n;
   logic        refresh_clock;
   logic        ext_timer_in;
   logic        use_ext_timer;
   logic        address_strobe_n;
   logic        last_transfer_flag_n;
   logic [31:0] proc_addr;
   logic        row_strobe;
   logic        dram_ready_out_n;
   logic        processor_cycle_active;
   logic        refresh_cycle_active;
   logic        refresh_request;
   logic        refresh_rearm_block;
   logic        divider_top_bit;
   logic        row_col_select;
   logic        low_addr_out_bit0;
   logic        low_addr_out_bit1;
   logic        ref_run;
   int          mismatches;
   int          checks_done;

   drfba_ctrl dut
   (
      .clk_sys,
      .arst_n,
      .refresh_clock,
      .ext_timer_in,
      .use_ext_timer,
      .address_strobe_n,
      .last_transfer_flag_n,
      .proc_addr,
      .row_strobe,
      .dram_ready_out_n,
      .processor_cycle_active,
      .refresh_cycle_active,
      .refresh_request,
      .refresh_rearm_block,
      .divider_top_bit,
      .row_col_select,
      .low_addr_out_bit0,
      .low_addr_out_bit1
   );

   drfba_row_model partner
   (
      .clk_sys,
      .arst_n,
      .address_strobe_n,
      .last_transfer_flag_n,
      .proc_addr,
      .dram_ready_out_n,
      .refresh_request,
      .refresh_cycle_active,
      .processor_cycle_active,
      .row_col_select,
      .row_strobe
   );

   initial
   begin
      clk_sys = 1'h0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Stopping the refresh clock freezes the divider between scenarios.
   initial
   begin
      refresh_clock = 1'h0;
      forever
      begin
         repeat (4) @(posedge clk_sys);
         if (ref_run)
            refresh_clock <= ~refresh_clock;
      end
   end

   task report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic wait_for(ref logic sig, input logic val, input int lim);
      int n;
      n = 0;
      while (sig !== val && n < lim)
      begin
         @(negedge clk_sys);
         n++;
      end
      if (sig !== val)
      begin
         mismatches++;
         $display("[ERR] %0t wait got %h exp %h", $time, sig, val);
         report_and_stop();
      end
   endtask

   // Last is raised ahead of the beat it closes, as the processor would.
   task automatic xfer(input logic [31:0] a, input int n, input logic [7:0] e, input logic chk);
      @(posedge clk_sys);
      address_strobe_n     <= 1'h0;
      proc_addr            <= a;
      last_transfer_flag_n <= (n == 1) ? 1'h0 : 1'h1;
      @(negedge clk_sys);
      `CHK(processor_cycle_active, 1'h0)
      @(posedge clk_sys);
      address_strobe_n <= 1'h1;
      @(negedge clk_sys);
      `CHK(processor_cycle_active, 1'h1)
      if (chk)
         `CHK({low_addr_out_bit1, low_addr_out_bit0}, {a[12], a[11]})
      for (int k = 0; k < n; k++)
      begin
         wait_for(dram_ready_out_n, 1'h0, 40);
         `CHK({low_addr_out_bit1, low_addr_out_bit0}, e[2*k +: 2])
         @(posedge clk_sys);
         last_transfer_flag_n <= (k + 2 == n) ? 1'h0 : 1'h1;
         @(negedge clk_sys);
      end
      `CHK(processor_cycle_active, 1'h0)
   endtask

   task automatic t_reset;
      @(negedge clk_sys);
      `CHK(dram_ready_out_n, 1'h1)
      `CHK(processor_cycle_active, 1'h0)
      `CHK({low_addr_out_bit1, low_addr_out_bit0}, 2'h0)
      $display("reset done");
   endtask

   task automatic t_bursts;
      logic [31:0] ad [6] = '{32'h0000_1800, 32'h0000_0800, 32'h0000_1000, 32'h0000_0008, 32'h0000_000C,
                              32'h0000_1000};
      int          nb [6] = '{4, 3, 2, 2, 1, 1};
      logic [7:0]  ex [6] = '{8'hE4, 8'h24, 8'h04, 8'h0E, 8'h03, 8'h00};
      for (int i = 0; i < 6; i++)
         xfer(ad[i], nb[i], ex[i], 1'h1);
      @(posedge clk_sys);
      address_strobe_n <= 1'h0;
      proc_addr        <= 32'hA000_1800;
      @(posedge clk_sys);
      address_strobe_n <= 1'h1;
      repeat (3) @(negedge clk_sys);
      `CHK(processor_cycle_active, 1'h0)
      $display("bursts done");
   endtask

   task automatic t_divider;
      int   hi;
      int   rq;
      logic prev;
      hi = 0;
      rq = 0;
      @(posedge clk_sys);
      ref_run <= 1'h1;
      wait_for(refresh_request, 1'h1, 400);
      repeat (100) @(negedge clk_sys);
      prev = refresh_request;
      repeat (224)
      begin
         @(negedge clk_sys);
         hi += (divider_top_bit === 1'h1);
         rq += (refresh_request === 1'h1 && prev === 1'h0);
         prev = refresh_request;
      end
      `CHK(hi, 96)
      `CHK(rq, 1)
      @(posedge clk_sys);
      ref_run <= 1'h0;
      $display("divider done");
   endtask

   task automatic t_ext;
      @(posedge clk_sys);
      use_ext_timer <= 1'h1;
      repeat (6) @(posedge clk_sys);
      fork
         xfer(32'h0000_1800, 4, 8'hE4, 1'h1);
         begin
            repeat (2) @(posedge clk_sys);
            ext_timer_in <= 1'h1;
         end
      join
      `CHK(refresh_request, 1'h1)
      `CHK(refresh_cycle_active, 1'h0)
      wait_for(refresh_cycle_active, 1'h1, 3);
      wait_for(refresh_cycle_active, 1'h0, 20);
      repeat (40) @(negedge clk_sys);
      `CHK(refresh_request, 1'h0)
      `CHK(refresh_rearm_block, 1'h1)
      @(posedge clk_sys);
      ext_timer_in <= 1'h0;
      repeat (6) @(negedge clk_sys);
      `CHK(refresh_rearm_block, 1'h0)
      $display("external timer done");
   endtask

   task automatic t_delayed;
      @(posedge clk_sys);
      ext_timer_in <= 1'h1;
      wait_for(refresh_request, 1'h1, 10);
      xfer(32'h0000_0008, 2, 8'h0E, 1'h0);
      `CHK(refresh_rearm_block, 1'h1)
      @(posedge clk_sys);
      ext_timer_in <= 1'h0;
      $display("delayed cycle done");
   endtask

   initial
   begin
      arst_n               = 1'h0;
      ext_timer_in         = 1'h0;
      use_ext_timer        = 1'h0;
      address_strobe_n     = 1'h1;
      last_transfer_flag_n = 1'h1;
      proc_addr            = 32'h0;
      ref_run              = 1'h0;
      mismatches           = 0;
      checks_done          = 0;
      @(posedge clk_sys);
      t_reset();
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'h1;
      repeat (3) @(posedge clk_sys);
      t_bursts();
      t_divider();
      t_ext();
      t_delayed();
      report_and_stop();
   end
endmodule
